// *** inc/ers_regs.svh ***
// Register map, field positions, reset values and timing counts
// of the receive sync status block. Definitions only.
`ifndef ERS_REGS_SVH
`define ERS_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ERS_OFS_CTRL 8'h00
`define ERS_OFS_EVT_STS 8'h04
`define ERS_OFS_EVT_CLR 8'h08
`define ERS_OFS_EVT_EN 8'h0C
`define ERS_OFS_SYNC_STS 8'h10

// ------------------------------------------------------------
// Receive sync status bit positions
// ------------------------------------------------------------
`define ERS_BIT_FRAME_LOSS 7
`define ERS_BIT_MF_LOSS 6
`define ERS_BIT_CRC_LOSS 5
`define ERS_BIT_EBIT1 4
`define ERS_BIT_EBIT2 3
`define ERS_BIT_CRC_TMO 2
`define ERS_BIT_RED 1
`define ERS_BIT_IWK 0

// Control bit positions
`define ERS_CTRL_MAINT 0
`define ERS_CTRL_AUTO_IWK 1

// Event bit positions
`define ERS_EVT_FRAME_LOSS 0
`define ERS_EVT_CRC_TMO 1
`define ERS_EVT_RED 2
`define ERS_EVT_MF_LOSS 3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ERS_RST_SYNC_STS 8'hE0
`define ERS_RST_CTRL 2'h2
`define ERS_RST_EVT 4'h0

// ------------------------------------------------------------
// Patterns, alignment counts and E bit frames
// ------------------------------------------------------------
`define ERS_FAS_PATTERN 7'h1B
`define ERS_MFAS_PATTERN 4'h0
`define ERS_FAS_LOSS_CNT 3
`define ERS_FAS_GAIN_CNT 2
`define ERS_MF_LOSS_CNT 2
`define ERS_MF_GAIN_CNT 1
`define ERS_EBIT1_FRAME 4'hD
`define ERS_EBIT2_FRAME 4'hF

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define ERS_CLK_NS 10
`define ERS_CRC_TMO_MS 8
`define ERS_RED_MS 100
`define ERS_CRC_TMO_CYC (`ERS_CRC_TMO_MS * 1000000 / `ERS_CLK_NS)
`define ERS_RED_CYC (`ERS_RED_MS * 1000000 / `ERS_CLK_NS)

`endif

// *** inc/ers_pkg.sv ***
// Types shared by the receive sync status block.
// Assumes ers_regs.svh supplies all numeric constants.
package ers_pkg;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ers_apb_req_type;

	// APB answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ers_apb_rsp_type;

	// Per-frame information from the receive framer
	typedef struct packed {
		logic frame_stb;
		logic [3:0] frame_num;
		logic [7:0] ts0;
		logic [7:0] ts16;
		logic crc_mf_lock;
	} ers_rx_type;

	// CRC-4 multiframe search states
	typedef enum logic [1:0] {
		ERS_CRC_IDLE = 2'b00,
		ERS_CRC_SEARCH = 2'b01,
		ERS_CRC_LOCKED = 2'b10,
		ERS_CRC_TIMEOUT = 2'b11
	} ers_crc_state_type;

endpackage : ers_pkg

// *** core/ers_timer.sv ***
// Persistence timer: expires after CYCLES clocks of run held high.
// Assumes a synchronous, already released active-low reset.
`timescale 1ns/10ps
module ers_timer import ers_pkg::*; #(
	parameter int CYCLES = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	output logic expired
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] cnt;
		logic exp;
	} ers_tmr_type;

	ers_tmr_type r, nxt;

	// Count while running; dropping run restarts from zero
	always_comb begin
		nxt = r;
		if (!run) begin
			nxt.cnt = 32'h0;
			nxt.exp = 1'b0;
		end else if (!r.exp) begin
			if (r.cnt >= 32'(CYCLES - 1)) begin
				nxt.exp = 1'b1;
			end else begin
				nxt.cnt = r.cnt + 32'h1;
			end
		end
	end

	// Registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end

	assign expired = r.exp;

endmodule : ers_timer

// *** core/ers_align_mon.sv ***
// Alignment monitor: declares loss after LOSS_CNT bad checks in a row
// and gain after GAIN_CNT good ones. Starts out lost.
`timescale 1ns/10ps
module ers_align_mon import ers_pkg::*; #(
	parameter int LOSS_CNT = 3,
	parameter int GAIN_CNT = 2
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic check,
	input wire logic match,
	input wire logic force_loss,
	output logic lost
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic lost;
		logic [3:0] run;
	} ers_mon_type;

	ers_mon_type r, nxt;

	// Count consecutive results that disagree with the current state
	always_comb begin
		nxt = r;
		if (force_loss) begin
			// Forced reframe restarts the search from scratch
			nxt.lost = 1'b1;
			nxt.run = 4'h0;
		end else if (check) begin
			if (r.lost == !match) begin
				nxt.run = 4'h0;
			end else if (r.lost && (r.run >= 4'(GAIN_CNT - 1))) begin
				nxt.lost = 1'b0;
				nxt.run = 4'h0;
			end else if (!r.lost && (r.run >= 4'(LOSS_CNT - 1))) begin
				nxt.lost = 1'b1;
				nxt.run = 4'h0;
			end else begin
				nxt.run = r.run + 4'h1;
			end
		end
	end

	// Registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{lost: 1'b1, run: 4'h0};
		end else begin
			r <= nxt;
		end
	end

	assign lost = r.lost;

endmodule : ers_align_mon

// *** core/ers_sync_status.sv ***
// Receive alignment and alarm status of an E1 framer, with APB access.
// Assumes per-frame framer data synchronous to mclk and an APB master.
//
// Functional notes
// - Bit 7 shows basic frame alignment lost
// - Bit 6 shows signalling multiframe alignment lost
// - Bit 5 shows CRC-4 multiframe alignment lost
// - Bit 4 holds first received E bit
// - Bit 3 holds second received E bit
// - Bit 2 flags CRC-4 search 8 ms timeout
// - Timeout in maintenance, no auto: force reframe
// - Bit 1 alarms after 100 ms frame loss
// - Alarm clears when frame alignment returns
// - Bit 0 shows far end runs CRC-4
// - Frame alignment judged on pattern 0011011
// - Multiframe alignment judged on TS16 0000
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "ers_regs.svh"
module ers_sync_status import ers_pkg::*; #(
	parameter int CRC_TMO_CYC = `ERS_CRC_TMO_CYC,
	parameter int RED_CYC = `ERS_RED_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire ers_apb_req_type apb_req,
	output ers_apb_rsp_type apb_rsp,
	input wire ers_rx_type rx,
	output logic reframe_req,
	output logic irq
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	// Two stages so the release is clean against mclk
	logic [1:0] rst_sync_r;
	logic rst_sys_n;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_sys_n = rst_sync_r[1];

	// ------------------------------------------------------------
	// Block state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] sts;             // Receive sync status word
		ers_crc_state_type crc_st;   // CRC-4 search state
		logic [1:0] ctrl;            // Maintenance and auto interworking
		logic [3:0] evt_sts;         // Sticky events
		logic [3:0] evt_en;          // Event enables
		logic irq;                   // Interrupt level
		logic reframe;               // Forced reframe pulse
		logic [31:0] prdata;         // Read data
		logic pready;                // Access answer
		logic pslverr;               // Unmapped address
	} ers_top_type;

	ers_top_type r, nxt;

	// Submodule results
	logic fas_lost;
	logic mf_lost;
	logic crc_tmo_exp;
	logic red_exp;

	// Decoded per-frame checks
	logic fas_frame;
	logic fas_check;
	logic mf_check;

	// Bus decode and new events
	logic setup_ph;
	logic wr_acc;
	logic [3:0] evt_now;

	// ------------------------------------------------------------
	// Frame and multiframe monitors
	// ------------------------------------------------------------
	// Even frames carry the alignment word
	assign fas_frame = rx.frame_stb && !rx.frame_num[0];
	assign fas_check = fas_frame;
	// Multiframe word only means anything once frames are aligned
	assign mf_check = rx.frame_stb && (rx.frame_num == 4'h0) && !fas_lost;

	// Basic frame alignment on bits two to eight of TS0
	ers_align_mon #(
		.LOSS_CNT(`ERS_FAS_LOSS_CNT),
		.GAIN_CNT(`ERS_FAS_GAIN_CNT)
	) u_fas_mon (
		.mclk(mclk),
		.rst_n(rst_sys_n),
		.check(fas_check),
		.match(rx.ts0[6:0] == `ERS_FAS_PATTERN),
		.force_loss(r.reframe),
		.lost(fas_lost)
	);

	// Signalling multiframe on TS16 bits one to four of frame zero
	ers_align_mon #(
		.LOSS_CNT(`ERS_MF_LOSS_CNT),
		.GAIN_CNT(`ERS_MF_GAIN_CNT)
	) u_mf_mon (
		.mclk(mclk),
		.rst_n(rst_sys_n),
		.check(mf_check),
		.match(rx.ts16[7:4] == `ERS_MFAS_PATTERN),
		.force_loss(fas_lost),
		.lost(mf_lost)
	);

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------
	// CRC-4 search window opens when basic alignment is found
	ers_timer #(
		.CYCLES(CRC_TMO_CYC)
	) u_crc_tmr (
		.mclk(mclk),
		.rst_n(rst_sys_n),
		.run(r.crc_st == ERS_CRC_SEARCH),
		.expired(crc_tmo_exp)
	);

	// Sustained loss timer runs only while frames are lost
	ers_timer #(
		.CYCLES(RED_CYC)
	) u_red_tmr (
		.mclk(mclk),
		.rst_n(rst_sys_n),
		.run(fas_lost),
		.expired(red_exp)
	);

	// ------------------------------------------------------------
	// Bus phase decode
	// ------------------------------------------------------------
	assign setup_ph = apb_req.psel && !apb_req.penable;
	// Writes land only on the edge that completes the access
	assign wr_acc = apb_req.psel && apb_req.penable && r.pready && apb_req.pwrite;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		nxt = r;
		nxt.reframe = 1'b0;

		// CRC-4 multiframe search
		case (r.crc_st)
			ERS_CRC_IDLE: begin
				// Wait for basic alignment before starting the window
				if (!fas_lost) begin
					nxt.crc_st = ERS_CRC_SEARCH;
					nxt.sts[`ERS_BIT_CRC_TMO] = 1'b0;
				end
			end
			ERS_CRC_SEARCH: begin
				if (rx.crc_mf_lock) begin
					nxt.crc_st = ERS_CRC_LOCKED;
					nxt.sts[`ERS_BIT_CRC_TMO] = 1'b0;
					nxt.sts[`ERS_BIT_IWK] = 1'b1;
				end else if (crc_tmo_exp) begin
					nxt.crc_st = ERS_CRC_TIMEOUT;
					nxt.sts[`ERS_BIT_CRC_TMO] = 1'b1;
					if (r.ctrl[`ERS_CTRL_AUTO_IWK]) begin
						// Far end seems not to send CRC-4
						nxt.sts[`ERS_BIT_IWK] = 1'b0;
					end else if (r.ctrl[`ERS_CTRL_MAINT]) begin
						nxt.reframe = 1'b1;
					end
				end
			end
			ERS_CRC_LOCKED: begin
				// Lost lock reopens a fresh window
				if (!rx.crc_mf_lock) begin
					nxt.crc_st = ERS_CRC_SEARCH;
				end
			end
			ERS_CRC_TIMEOUT: begin
				// A late lock still counts; timeout flag is kept until then or until a new window opens
				if (rx.crc_mf_lock) begin
					nxt.crc_st = ERS_CRC_LOCKED;
					nxt.sts[`ERS_BIT_CRC_TMO] = 1'b0;
					nxt.sts[`ERS_BIT_IWK] = 1'b1;
				end
			end
			default: begin
				nxt.crc_st = ERS_CRC_IDLE;
			end
		endcase
		// Any frame loss aborts the CRC-4 search
		if (fas_lost) begin
			nxt.crc_st = ERS_CRC_IDLE;
		end

		// Alignment bits follow the monitors and the CRC-4 search state every cycle
		nxt.sts[`ERS_BIT_FRAME_LOSS] = fas_lost;
		nxt.sts[`ERS_BIT_MF_LOSS] = mf_lost || fas_lost;
		nxt.sts[`ERS_BIT_CRC_LOSS] = (nxt.crc_st != ERS_CRC_LOCKED);
		// Alarm drops in the same cycle alignment returns
		nxt.sts[`ERS_BIT_RED] = red_exp && fas_lost;

		// E bits ride in bit one of frames 13 and 15 of a CRC multiframe
		if (rx.frame_stb && (r.crc_st == ERS_CRC_LOCKED)) begin
			if (rx.frame_num == `ERS_EBIT1_FRAME) begin
				nxt.sts[`ERS_BIT_EBIT1] = rx.ts0[7];
			end
			if (rx.frame_num == `ERS_EBIT2_FRAME) begin
				nxt.sts[`ERS_BIT_EBIT2] = rx.ts0[7];
			end
		end

		// Rising edges of the alarms become events
		evt_now = 4'h0;
		evt_now[`ERS_EVT_FRAME_LOSS] = nxt.sts[`ERS_BIT_FRAME_LOSS] && !r.sts[`ERS_BIT_FRAME_LOSS];
		evt_now[`ERS_EVT_CRC_TMO] = nxt.sts[`ERS_BIT_CRC_TMO] && !r.sts[`ERS_BIT_CRC_TMO];
		evt_now[`ERS_EVT_RED] = nxt.sts[`ERS_BIT_RED] && !r.sts[`ERS_BIT_RED];
		evt_now[`ERS_EVT_MF_LOSS] = nxt.sts[`ERS_BIT_MF_LOSS] && !r.sts[`ERS_BIT_MF_LOSS];

		// Register writes
		if (wr_acc) begin
			case (apb_req.paddr)
				`ERS_OFS_CTRL: begin
					nxt.ctrl = apb_req.pwdata[1:0];
				end
				`ERS_OFS_EVT_CLR: begin
					nxt.evt_sts = r.evt_sts & ~apb_req.pwdata[3:0];
				end
				`ERS_OFS_EVT_EN: begin
					nxt.evt_en = apb_req.pwdata[3:0];
				end
				default: begin
					// Read-only and unmapped writes are dropped
				end
			endcase
		end
		// New events win over a clear in the same cycle
		nxt.evt_sts = nxt.evt_sts | evt_now;
		nxt.irq = |(nxt.evt_sts & nxt.evt_en);

		// Answer one cycle after setup; data captured at setup
		nxt.pready = setup_ph;
		if (setup_ph) begin
			nxt.pslverr = 1'b0;
			nxt.prdata = 32'h0;
			// Reading never alters any status bit
			case (apb_req.paddr)
				`ERS_OFS_CTRL: begin
					nxt.prdata = {30'h0, r.ctrl};
				end
				`ERS_OFS_EVT_STS: begin
					nxt.prdata = {28'h0, r.evt_sts};
				end
				`ERS_OFS_EVT_CLR: begin
					nxt.prdata = 32'h0;
				end
				`ERS_OFS_EVT_EN: begin
					nxt.prdata = {28'h0, r.evt_en};
				end
				`ERS_OFS_SYNC_STS: begin
					nxt.prdata = {24'h0, r.sts};
				end
				default: begin
					nxt.pslverr = 1'b1;
				end
			endcase
		end else if (!apb_req.psel) begin
			nxt.pslverr = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_sys_n) begin
		if (!rst_sys_n) begin
			r <= '{
				sts: `ERS_RST_SYNC_STS,
				crc_st: ERS_CRC_IDLE,
				ctrl: `ERS_RST_CTRL,
				evt_sts: `ERS_RST_EVT,
				evt_en: `ERS_RST_EVT,
				irq: 1'b0,
				reframe: 1'b0,
				prdata: 32'h0,
				pready: 1'b0,
				pslverr: 1'b0
			};
		end else begin
			r <= nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all straight from flops
	// ------------------------------------------------------------
	assign apb_rsp.prdata = r.prdata;
	assign apb_rsp.pready = r.pready;
	assign apb_rsp.pslverr = r.pslverr;
	assign reframe_req = r.reframe;
	assign irq = r.irq;

endmodule : ers_sync_status

// *** tb/ers_far_end.sv ***
// Far-end E1 line model: one frame strobe every 4 clocks.
// Assumes the bench sets fas_ok, lock and ebits between frames.
`timescale 1ns/10ps
`include "ers_regs.svh"
module ers_far_end import ers_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fas_ok,
	input wire logic lock,
	input wire logic [1:0] ebits,
	output ers_rx_type rx
);
	logic [1:0] ph_r; // Clock within slot
	logic [3:0] fn_r; // Frame in multiframe
	logic sp; // E bit or spare
	assign sp = (fn_r == 4'hD) ? ebits[1] : (fn_r == 4'hF) ? ebits[0] : 1'b1;
	// Frames; lines toggle between strobes so stale data never passes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ph_r <= 2'h0;
			fn_r <= 4'h0;
			rx <= '0;
		end else begin
			ph_r <= ph_r + 2'h1;
			rx.crc_mf_lock <= lock;
			rx.frame_stb <= (ph_r == 2'h3);
			if (ph_r == 2'h3) begin
				fn_r <= fn_r + 4'h1;
				rx.frame_num <= fn_r;
				rx.ts0 <= fn_r[0] ? {sp, 7'h40} : {1'b1, fas_ok ? `ERS_FAS_PATTERN : 7'h00};
				rx.ts16 <= {(fn_r == 4'h0) ? `ERS_MFAS_PATTERN : 4'hF, 4'hB};
			end else begin
				rx.frame_num <= ~rx.frame_num;
				rx.ts0 <= ~rx.ts0;
				rx.ts16 <= ~rx.ts16;
			end
		end
	end
endmodule : ers_far_end

// *** tb/ers_sync_status_properties.sv ***
// Port-level checks of the sync status block.
// Assumes APB with psel held through the access phase.
`timescale 1ns/10ps
`include "ers_regs.svh"
module ers_sync_status_properties import ers_pkg::*; #(
	parameter int CRC_TMO_CYC = 40,
	parameter int RED_CYC = 100
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire ers_apb_req_type apb_req,
	input wire ers_apb_rsp_type apb_rsp,
	input wire ers_rx_type rx,
	input wire logic reframe_req,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic rd_s; // Status read completing
	logic map; // Address decodes
	assign rd_s = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == `ERS_OFS_SYNC_STS;
	assign map = apb_req.paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	property p_ans; apb_req.psel && !apb_req.penable |=> apb_rsp.pready; endproperty
	a_ans: assert property (p_ans) else $error("no answer after setup");
	property p_one; apb_rsp.pready |=> !apb_rsp.pready; endproperty
	a_one: assert property (p_one) else $error("pready too long");
	property p_err; apb_rsp.pready && !map |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
	property p_ok; apb_rsp.pready && map |-> !apb_rsp.pslverr; endproperty
	a_ok: assert property (p_ok) else $error("mapped refused");
	property p_hi; rd_s |-> apb_rsp.prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("status upper bits set");
	property p_mf; rd_s && apb_rsp.prdata[7] |-> apb_rsp.prdata[6]; endproperty
	a_mf: assert property (p_mf) else $error("mf aligned without frame");
	property p_red; rd_s && !apb_rsp.prdata[7] |-> !apb_rsp.prdata[1]; endproperty
	a_red: assert property (p_red) else $error("alarm while aligned");
	property p_rf; reframe_req |=> !reframe_req; endproperty
	a_rf: assert property (p_rf) else $error("reframe not a pulse");
	property p_clr; apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 8'h08 |-> apb_rsp.prdata == 32'h0;
	endproperty
	a_clr: assert property (p_clr) else $error("clear reg reads nonzero");
	c_rf: cover property (reframe_req);
	c_irq: cover property ($rose(irq));
	c_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule : ers_sync_status_properties

// *** tb/tb_ers_sync_status.sv ***
// Self-checking bench of the sync status block.
// Assumes the far-end model feeds the framer inputs.
`timescale 1ns/10ps
`include "ers_regs.svh"
module tb_ers_sync_status import ers_pkg::*; ();
	localparam int TMO = 40; // Shortened search timeout
	localparam int SUSTAINED_FRAME_LOSS_ALARM = 100; // Shortened alarm delay
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	ers_apb_req_type req = '0;
	ers_apb_rsp_type rsp;
	ers_rx_type rx;
	logic reframe_req;
	logic irq;
	logic fas_ok = 1'b0; // Far end sends good FAS
	logic lock = 1'b0; // Far end CRC-4 lock
	logic [1:0] ebits = 2'h2;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	int n_rf = 0; // Reframe pulses seen
	logic [31:0] rd;
	logic er;
	always #5 mclk = ~mclk;
	ers_sync_status #(.CRC_TMO_CYC(TMO), .RED_CYC(SUSTAINED_FRAME_LOSS_ALARM)) dut_u (.mclk(mclk), .rst_n(rst_n), .apb_req(req),
		.apb_rsp(rsp), .rx(rx), .reframe_req(reframe_req), .irq(irq));
	ers_far_end far_u (.mclk(mclk), .rst_n(rst_n), .fas_ok(fas_ok), .lock(lock), .ebits(ebits), .rx(rx));
	// Hang guard and reframe pulse count
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (reframe_req === 1'b1) n_rf <= n_rf + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			close_out();
		end
	end
	task automatic close_out();
		$display("counts comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge mclk);
		req.penable <= 1'b1;
		@(posedge mclk);
		while (rsp.pready !== 1'b1) @(posedge mclk);
		// Answer taken at the completing edge, then the request is released
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask : apb
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask : wt
	task automatic t_reset();
		apb(1'b0, `ERS_OFS_SYNC_STS, 32'h0);
		chk("sts", 32'hE0, rd);
		apb(1'b1, `ERS_OFS_SYNC_STS, 32'hFF);
		apb(1'b0, `ERS_OFS_SYNC_STS, 32'h0);
		chk("sts ro", 32'hE0, rd);
		apb(1'b0, 8'h20, 32'h0);
		chk("err", 32'h1, {31'h0, er});
		$display("test reset done");
	endtask : t_reset
	task automatic t_red();
		wt(SUSTAINED_FRAME_LOSS_ALARM + 40);
		apb(1'b0, `ERS_OFS_SYNC_STS, 32'h0);
		chk("red on", 32'hE2, rd);
		fas_ok <= 1'b1;
		wt(40);
		apb(1'b0, `ERS_OFS_SYNC_STS, 32'h0);
		chk("red off", 32'h0, rd & 32'h82);
		$display("test red done");
	endtask : t_red
	task automatic t_tmo();
		apb(1'b1, `ERS_OFS_EVT_EN, 32'h2);
		wt(TMO + 100);
		apb(1'b0, `ERS_OFS_SYNC_STS, 32'h0);
		chk("tmo", 32'h24, rd & 32'hE5);
		chk("no rf", 32'h0, n_rf);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, `ERS_OFS_EVT_EN, 32'h0);
		wt(2);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `ERS_OFS_EVT_EN, 32'h2);
		wt(2);
		chk("irq back", 32'h1, {31'h0, irq});
		apb(1'b1, `ERS_OFS_EVT_CLR, 32'h2);
		wt(2);
		chk("irq clr", 32'h0, {31'h0, irq});
		$display("test timeout done");
	endtask : t_tmo
	task automatic t_lock();
		lock <= 1'b1;
		wt(140);
		apb(1'b0, `ERS_OFS_SYNC_STS, 32'h0);
		chk("lock e1", 32'h11, rd);
		ebits <= 2'h1;
		wt(140);
		apb(1'b0, `ERS_OFS_SYNC_STS, 32'h0);
		chk("lock e2", 32'h09, rd);
		$display("test lock done");
	endtask : t_lock
	task automatic t_rf();
		apb(1'b1, `ERS_OFS_CTRL, 32'h1);
		lock <= 1'b0;
		fas_ok <= 1'b0;
		wt(40);
		fas_ok <= 1'b1;
		for (int i = 0; i < 300 && n_rf == 0; i++) wt(1);
		chk("reframe", 32'h1, {31'h0, n_rf != 0});
		apb(1'b0, `ERS_OFS_SYNC_STS, 32'h0);
		chk("rf loss", 32'h80, rd & 32'h80);
		$display("test reframe done");
	endtask : t_rf
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_red();
		t_tmo();
		t_lock();
		t_rf();
		close_out();
	end
endmodule : tb_ers_sync_status
bind ers_sync_status ers_sync_status_properties #(.CRC_TMO_CYC(CRC_TMO_CYC), .RED_CYC(RED_CYC)) u_props (
	.mclk(mclk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .rx(rx), .reframe_req(reframe_req),
	.irq(irq));
